/* File: hdl/cds_serial_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

module cds_serial_ctrl (
   input wire logic clk,
   input wire logic sys_rst,
   input wire cds_pkg::cds_pins_t pins,
   output logic sdoOut,
   output logic sdoOe,
   output logic faultOut,
   output logic faultOe,
   output logic openLoopAlarmOut,
   output logic openLoopAlarmOe,
   output logic thermalAlarmOut,
   output logic thermalAlarmOe,
   output logic driveEnable,
   output logic clearActive,
   output logic clearToMid,
   output logic [3:0] rangeCode,
   output logic senseResistorSelect,
   output cds_pkg::cds_range_t rangeKind,
   output cds_pkg::cds_status_t statusFlags
);
   import cds_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers

   cds_pins_t meta_r, pin_r;
   logic sclkD_r, syncD_r;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         // strobe starts at its idle level so no false edge follows reset
         meta_r <= '{sync: 1'b1, default: '0};
         pin_r <= '{sync: 1'b1, default: '0};
         sclkD_r <= 1'b0;
         syncD_r <= 1'b1;
      end else begin
         meta_r <= pins;
         pin_r <= meta_r;
         sclkD_r <= pin_r.sclk;
         syncD_r <= pin_r.sync;
      end
   end

   logic sclkRise, syncRise, syncFall, frameOn, hwMode;
   assign sclkRise = pin_r.sclk && !sclkD_r;
   assign syncRise = pin_r.sync && !syncD_r;
   assign syncFall = !pin_r.sync && syncD_r;
   assign frameOn = !pin_r.sync && !syncFall;
   assign hwMode = pin_r.hwSel;

   ////////////////////////////////////////////////////////////////////
   // frame shifter

   logic [CRC_FRAME_BITS-1:0] shift_r, shift_nxt;
   logic [CNT_BITS-1:0] bitCnt_r;

   assign shift_nxt = {shift_r[CRC_FRAME_BITS-2:0], pin_r.sdi};

   always_ff @(posedge clk) begin
      if (sys_rst || syncFall) begin
         shift_r <= '0;
         bitCnt_r <= '0;
      end else if (frameOn && sclkRise) begin
         shift_r <= shift_nxt;
         if (bitCnt_r != CNT_MAX)
            bitCnt_r <= bitCnt_r + 5'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // control word and status

   cds_ctrl_t ctrl_r;
   cds_status_t status_r;
   logic softRst_r;

   // frame decode at the strobe rise; short frames sit in the low bits
   logic [FRAME_BITS-1:0] word;
   logic [CRC_BITS-1:0] crcCalc;
   logic longFrame, sizeOk, addrHit, crcOk, commit, crcFail, isRead;

   assign longFrame = bitCnt_r == CNT_LONG;
   assign sizeOk = longFrame || bitCnt_r == CNT_SHORT;
   assign word = longFrame ? shift_r[CRC_FRAME_BITS-1:CRC_BITS] :
                 shift_r[FRAME_BITS-1:0];
   assign addrHit = word[POS_ADDR_HI:POS_ADDR_LO] == pin_r.addrStrap;
   assign crcOk = !longFrame || crcCalc == shift_r[CRC_BITS-1:0];
   assign commit = syncRise && sizeOk && addrHit && crcOk;
   assign crcFail = syncRise && longFrame && addrHit && !crcOk;
   assign isRead = commit && word[POS_RW] && !hwMode;

   cds_crc8 #(
      .DATA_BITS(FRAME_BITS)
   ) crcUnit (
      .data(word),
      .crc(crcCalc)
   );

   // reset bit applied one cycle after the frame so the frame itself ends cleanly
   always_ff @(posedge clk) begin
      if (sys_rst)
         softRst_r <= 1'b0;
      else
         softRst_r <= commit && word[POS_RESET];
   end

   always_ff @(posedge clk) begin
      if (sys_rst || softRst_r) begin
         ctrl_r <= CTRL_RST;
      end else if (commit) begin
         // read frames write too
         ctrl_r.rangeCode <= word[POS_RANGE_HI:POS_RANGE_LO];
         ctrl_r.clear_level_select <= word[POS_CLEAR_LEVEL_SELECT];
         ctrl_r.driveEn <= word[POS_DRIVE];
         ctrl_r.swClear <= word[POS_CLEAR];
         ctrl_r.senseSel <= word[POS_SENSE];
      end
   end

   // fault flags from the output stage are live; only the crc flag sticks
   always_ff @(posedge clk) begin
      if (sys_rst || softRst_r) begin
         status_r <= '0;
      end else begin
         status_r.openLoop <= pin_r.openLoop;
         status_r.overTemp <= pin_r.overTemp;
         if (crcFail)
            status_r.pecErr <= 1'b1;
         else if (isRead)
            status_r.pecErr <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // readback

   logic readHit_r, sdoOut_r, sdoOe_r;
   logic [FRAME_BITS-1:0] readSh_r;
   logic [FRAME_BITS-1:0] readWord;
   logic [3:0] hdr;

   assign hdr = shift_nxt[3:0];
   assign readWord = {pin_r.addrStrap, 1'b1, 1'b0, ctrl_r.rangeCode, ctrl_r.clear_level_select,
                      ctrl_r.driveEn, ctrl_r.senseSel, status_r.pecErr,
                      status_r.overTemp, status_r.openLoop, 1'b0};

   always_ff @(posedge clk) begin
      if (sys_rst || syncRise || syncFall) begin
         readHit_r <= 1'b0;
         readSh_r <= '0;
         sdoOut_r <= 1'b0;
         sdoOe_r <= 1'b0;
      end else if (frameOn && sclkRise) begin
         if (bitCnt_r == ADDR_CHECK_EDGE - 5'h01) begin
            // header complete on this edge: address, then read flag
            readHit_r <= hdr[3:1] == pin_r.addrStrap && hdr[0] && !hwMode;
            readSh_r <= readWord;
         end else if (bitCnt_r == SDO_START_EDGE - 5'h01 && readHit_r) begin
            sdoOe_r <= 1'b1;
            sdoOut_r <= readSh_r[FRAME_BITS-1];
            readSh_r <= {readSh_r[FRAME_BITS-2:0], 1'b0};
         end else if (sdoOe_r) begin
            sdoOut_r <= readSh_r[FRAME_BITS-1];
            readSh_r <= {readSh_r[FRAME_BITS-2:0], 1'b0};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // effective configuration and pins

   logic [3:0] rangeEff;
   logic senseEff;
   cds_range_t rangeKind_r;
   logic [3:0] rangeCode_r;
   logic sense_r, drive_r, clear_r, clrMid_r;
   logic faultOe_r, openOe_r, thermOe_r;

   assign rangeEff = hwMode ? pin_r.rangePin : ctrl_r.rangeCode;
   assign senseEff = hwMode ? pin_r.senseSelPin : ctrl_r.senseSel;

   // unused codes decode to invalid; host must avoid them
   function automatic cds_range_t decodeRange(logic [3:0] code, logic internal);
      cds_range_t k;
      k = RNG_INVALID;
      unique case (code)
         RANGE_4_20: k = RNG_4_20;
         RANGE_0_24: k = RNG_0_24;
         RANGE_4_20_OVR: k = internal ? RNG_3P92_20P4 : RNG_INVALID;
         RANGE_0_24_OVR: k = internal ? RNG_0_24P5 : RNG_INVALID;
         default: k = RNG_INVALID;
      endcase
      return k;
   endfunction

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rangeKind_r <= RNG_4_20;
         rangeCode_r <= CTRL_RST.rangeCode;
         sense_r <= CTRL_RST.senseSel;
      end else begin
         rangeKind_r <= decodeRange(rangeEff, senseEff);
         rangeCode_r <= rangeEff;
         sense_r <= senseEff;
      end
   end

   // clear select is the or of pin and bit
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         drive_r <= 1'b0;
         clear_r <= 1'b0;
         clrMid_r <= 1'b0;
      end else begin
         drive_r <= ctrl_r.driveEn;
         clear_r <= ctrl_r.swClear || pin_r.clearPin;
         clrMid_r <= ctrl_r.clear_level_select || pin_r.clrSelPin;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         faultOe_r <= 1'b0;
         openOe_r <= 1'b0;
         thermOe_r <= 1'b0;
      end else begin
         faultOe_r <= !hwMode && (status_r != '0);
         openOe_r <= hwMode && pin_r.openLoop;
         thermOe_r <= hwMode && pin_r.overTemp;
      end
   end

   assign sdoOut = sdoOut_r;
   assign sdoOe = sdoOe_r;
   assign faultOut = 1'b0;
   assign faultOe = faultOe_r;
   assign openLoopAlarmOut = 1'b0;
   assign openLoopAlarmOe = openOe_r;
   assign thermalAlarmOut = 1'b0;
   assign thermalAlarmOe = thermOe_r;
   assign driveEnable = drive_r;
   assign clearActive = clear_r;
   assign clearToMid = clrMid_r;
   assign rangeCode = rangeCode_r;
   assign senseResistorSelect = sense_r;
   assign rangeKind = rangeKind_r;
   assign statusFlags = status_r;

   ////////////////////////////////////////////////////////////////////
   // checks

   range_overrange_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      (senseEff && rangeEff == RANGE_0_24_OVR) |=> rangeKind_r == RNG_0_24P5)
      else $error("overrange code not decoded");

   drive_off_reset_a:
   assert property (@(posedge clk) sys_rst ##1 !sys_rst |-> !drive_r ##1 !drive_r)
      else $error("drive enabled after reset");

   clear_level_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      ctrl_r.clear_level_select |=> clrMid_r)
      else $error("clear level not midscale");

   soft_reset_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      commit && word[POS_RESET] |=> ##1 ctrl_r == CTRL_RST && !status_r.pecErr)
      else $error("reset bit did not restore defaults");

   sdo_start_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      $rose(sdoOe_r) |-> bitCnt_r == SDO_START_EDGE && !hwMode)
      else $error("data output enabled at wrong edge");

   sdo_release_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      syncRise |=> !sdoOe_r [*2])
      else $error("data output not released at strobe rise");

   read_writes_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      isRead && !word[POS_RESET] |=> ctrl_r.driveEn == $past(word[POS_DRIVE]))
      else $error("read frame did not write");

   addr_miss_a:
   assert property (@(posedge clk) disable iff (sys_rst || softRst_r)
      syncRise && !addrHit |=> $stable(ctrl_r))
      else $error("frame for another address acted on");

   crc_fail_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      crcFail |=> status_r.pecErr ##1 (faultOe_r || hwMode))
      else $error("crc failure not flagged");

   pec_clear_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      isRead && !crcFail |=> !status_r.pecErr)
      else $error("interface error not cleared by read");

   hw_alarm_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      hwMode && pin_r.overTemp |=> thermOe_r && !faultOe_r)
      else $error("thermal alarm not asserted");

   fault_sw_only_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      hwMode |=> !faultOe_r)
      else $error("shared fault driven in pin mode");

   open_alarm_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      hwMode && pin_r.openLoop |=> openOe_r)
      else $error("open loop alarm not asserted");

   pin_range_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      hwMode |=> rangeCode_r == $past(pin_r.rangePin) && sense_r == $past(pin_r.senseSelPin))
      else $error("pin mode range not taken from pins");

   sdo_idle_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      !frameOn |=> !sdoOe_r)
      else $error("data output driven outside a frame");

   drive_write_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      commit && !word[POS_DRIVE] |=> !ctrl_r.driveEn)
      else $error("drive left on after enable written 0");

endmodule // cds_serial_ctrl

`default_nettype wire

/* File: hdl/cds_pkg.sv */
package cds_pkg;

   // frame geometry
   localparam int FRAME_BITS = 16;
   localparam int CRC_BITS = 8;
   localparam int CRC_FRAME_BITS = 24;
   localparam int CNT_BITS = 5;
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [7:0] CRC_INIT = 8'h00;

   // link edges, counted from the frame start
   localparam logic [4:0] ADDR_CHECK_EDGE = 5'h04;
   localparam logic [4:0] SDO_START_EDGE = 5'h05;
   localparam logic [4:0] CNT_SHORT = 5'h10;
   localparam logic [4:0] CNT_LONG = 5'h18;
   localparam logic [4:0] CNT_MAX = 5'h1f;

   // write frame field positions
   localparam int POS_ADDR_HI = 15;
   localparam int POS_ADDR_LO = 13;
   localparam int POS_RW = 12;
   localparam int POS_RANGE_HI = 10;
   localparam int POS_RANGE_LO = 7;
   localparam int POS_CLEAR_LEVEL_SELECT = 6;
   localparam int POS_DRIVE = 5;
   localparam int POS_CLEAR = 4;
   localparam int POS_SENSE = 3;
   localparam int POS_RESET = 2;

   // valid range codes
   localparam logic [3:0] RANGE_4_20 = 4'h0;
   localparam logic [3:0] RANGE_0_24 = 4'h2;
   localparam logic [3:0] RANGE_4_20_OVR = 4'hd;
   localparam logic [3:0] RANGE_0_24_OVR = 4'hf;

   typedef enum logic [2:0] {
      RNG_INVALID,
      RNG_4_20,
      RNG_0_24,
      RNG_3P92_20P4,
      RNG_0_24P5
   } cds_range_t;

   // output_control_word settings
   typedef struct packed {
      logic [3:0] rangeCode;
      logic clear_level_select;
      logic driveEn;
      logic swClear;
      logic senseSel;
   } cds_ctrl_t;

   localparam cds_ctrl_t CTRL_RST = '0;

   typedef struct packed {
      logic pecErr;
      logic overTemp;
      logic openLoop;
   } cds_status_t;

   // every pin that crosses into the clk domain
   typedef struct packed {
      logic sclk;
      logic sync;
      logic sdi;
      logic hwSel;
      logic clearPin;
      logic clrSelPin;
      logic openLoop;
      logic overTemp;
      logic senseSelPin;
      logic [3:0] rangePin;
      logic [2:0] addrStrap;
   } cds_pins_t;

endpackage

/* File: hdl/cds_crc8.sv */
`timescale 1ns/1ps
`default_nettype none

module cds_crc8 #(
   parameter int DATA_BITS = 16
) (
   input wire logic [DATA_BITS-1:0] data,
   output logic [cds_pkg::CRC_BITS-1:0] crc
);
   import cds_pkg::*;

   // msb-first serial crc, unrolled by the loop
   always_comb begin
      logic fb;
      fb = 1'b0;
      crc = CRC_INIT;
      for (int i = DATA_BITS - 1; i >= 0; i--) begin
         fb = crc[7] ^ data[i];
         crc = {crc[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
      end
   end

endmodule // cds_crc8

`default_nettype wire

/* File: sim/cds_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// host serial master; link clock idles low and only moves inside frames
module cds_host_model (
   input wire logic clk,
   input wire logic sdoLine,
   input wire logic sdoOe,
   output logic sclk,
   output logic syncN,
   output logic sdi
);
   import cds_pkg::*;
   initial begin
      sclk = 1'b0;
      syncN = 1'b1;
      sdi = 1'b0;
   end
   // msb first, 25 clk link period, strobe low for the whole frame
   task automatic xfer(input int n, input logic [23:0] w, output logic [15:0] rd,
      output logic [1:0] oe);
      rd = '0;
      oe = '0;
      @(negedge clk);
      syncN <= 1'b0;
      sdi <= w[n-1];
      repeat (13) @(negedge clk);
      for (int i = 0; i < n; i++) begin
         sclk <= 1'b1;
         repeat (12) @(negedge clk);
         sclk <= 1'b0;
         if (i == 3) oe[0] = sdoOe;
         if (i == 4) oe[1] = sdoOe;
         if (i >= 4 && i < 20) rd[19-i] = sdoLine;
         if (i < n - 1) sdi <= w[n-2-i];
         repeat (13) @(negedge clk);
      end
      syncN <= 1'b1;
      // released data line shows the inverse, never a stale level
      sdi <= ~sdi;
   endtask
endmodule // cds_host_model
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
   $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
////////////////////////////////////////////////////////////////////////////////
module tb_top;
   import cds_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   cds_pins_t cfg, pins;
   logic sclk, syncN, sdi, sdoOut, sdoOe, sdoLine, fOut, fOe, olOut, olOe, tOut, tOe;
   logic sdoLast = 1'b0;
   logic drv, clrA, clrMid, sense, pec;
   logic [3:0] rng;
   logic [15:0] rd;
   logic [1:0] oe;
   cds_range_t kind;
   cds_status_t st;
   cds_ctrl_t ec, c;
   logic [3:0] rtab [4] = '{RANGE_4_20, RANGE_0_24, RANGE_4_20_OVR, RANGE_0_24_OVR};
   int err_count = 0;
   int n_tests = 0;
   always #2.5 clk = ~clk;
   always_comb begin
      pins = cfg;
      pins.sclk = sclk;
      pins.sync = syncN;
      pins.sdi = sdi;
   end
   // undriven output line: inverse of the last driven level
   always @(posedge clk) if (sdoOe) sdoLast <= sdoOut;
   assign sdoLine = sdoOe ? sdoOut : ~sdoLast;
   cds_serial_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .pins(pins), .sdoOut(sdoOut),
      .sdoOe(sdoOe), .faultOut(fOut), .faultOe(fOe), .openLoopAlarmOut(olOut),
      .openLoopAlarmOe(olOe), .thermalAlarmOut(tOut), .thermalAlarmOe(tOe),
      .driveEnable(drv), .clearActive(clrA), .clearToMid(clrMid), .rangeCode(rng),
      .senseResistorSelect(sense), .rangeKind(kind), .statusFlags(st));
   cds_host_model u_host (.clk(clk), .sdoLine(sdoLine), .sdoOe(sdoOe), .sclk(sclk),
      .syncN(syncN), .sdi(sdi));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic cds_range_t kind_of(input logic s, input logic [3:0] r);
      if (r == RANGE_4_20) return RNG_4_20;
      if (r == RANGE_0_24) return RNG_0_24;
      if (s && r == RANGE_4_20_OVR) return RNG_3P92_20P4;
      if (s && r == RANGE_0_24_OVR) return RNG_0_24P5;
      return RNG_INVALID;
   endfunction
   function automatic logic [7:0] crc_of(input logic [15:0] d);
      logic [7:0] x;
      x = CRC_INIT;
      for (int i = 15; i >= 0; i--) x = {x[6:0], 1'b0} ^ ((x[7] ^ d[i]) ? CRC_POLY : 8'h00);
      return x;
   endfunction
   task automatic chk_out();
      `CHK(rng, ec.rangeCode)
      `CHK(sense, ec.senseSel)
      `CHK(kind, kind_of(ec.senseSel, ec.rangeCode))
      `CHK(drv, ec.driveEn)
      `CHK(clrA, ec.swClear | cfg.clearPin)
      `CHK(clrMid, ec.clear_level_select | cfg.clrSelPin)
      `CHK(st, {pec, cfg.overTemp, cfg.openLoop})
      `CHK(fOe, pec | cfg.overTemp | cfg.openLoop)
      `CHK({fOut, sdoOe}, 2'b00)
   endtask
   // frame with optional check byte; bad flips one bit of it
   task automatic send(input logic [2:0] a, input logic rw, input logic rst, input bit crc,
      input bit bad);
      logic [15:0] w, er;
      logic m;
      w = {a, rw, 1'b0, c.rangeCode, c.clear_level_select, c.driveEn, c.swClear, c.senseSel, rst, 2'b00};
      m = (a == cfg.addrStrap);
      er = {cfg.addrStrap, 2'b10, ec.rangeCode, ec.clear_level_select, ec.driveEn, ec.senseSel, pec,
         cfg.overTemp, cfg.openLoop, 1'b0};
      u_host.xfer(crc ? 24 : 16, crc ? {w, crc_of(w) ^ {7'h00, bad}} : {8'h00, w}, rd, oe);
      if (m && bad) pec = 1'b1;
      else if (m && rw) pec = 1'b0;
      if (m && !bad) ec = rst ? CTRL_RST : c;
      if (m && !bad && rst) pec = 1'b0;
      repeat (8) @(negedge clk);
      `CHK(oe, {m & rw, 1'b0})
      if (m && rw) `CHK(rd & (crc ? 16'hffff : 16'hfff0), er & (crc ? 16'hffff : 16'hfff0))
      chk_out();
   endtask
   task automatic test_end(input string s);
      $display("test %s done", s);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #300us;
      err_count++;
      final_report();
   end
   initial begin
      cfg = '0;
      cfg.addrStrap = 3'h5;
      ec = CTRL_RST;
      pec = 1'b0;
      void'($urandom(32'h9bad637d));
      repeat (10) @(negedge clk);
      sys_rst = 1'b0;
      repeat (8) @(negedge clk);
      `CHK(kind, RNG_4_20)
      chk_out();
      test_end("reset");
      for (int i = 0; i < 4; i++) begin
         c = '0;
         c.rangeCode = rtab[i];
         c.senseSel = 1'b1;
         c.driveEn = 1'b1;
         send(cfg.addrStrap, 1'b0, 1'b0, 1'b0, 1'b0);
      end
      test_end("ranges");
      for (int i = 0; i < 16; i++) begin
         cfg.addrStrap = 3'($urandom);
         cfg.clearPin = 1'($urandom);
         cfg.clrSelPin = 1'($urandom);
         c = cds_ctrl_t'(8'($urandom));
         c.rangeCode = rtab[$urandom_range(c.senseSel ? 3 : 1)];
         // a quarter of the frames go to another address
         send(($urandom_range(3) == 0) ? cfg.addrStrap ^ 3'h3 : cfg.addrStrap,
            1'($urandom), 1'b0, 1'($urandom), 1'b0);
      end
      test_end("random");
      c.driveEn = ~c.driveEn;
      send(cfg.addrStrap, 1'b0, 1'b0, 1'b1, 1'b1);
      send(cfg.addrStrap, 1'b1, 1'b0, 1'b1, 1'b0);
      send(cfg.addrStrap, 1'b0, 1'b0, 1'b1, 1'b1);
      send(cfg.addrStrap, 1'b0, 1'b1, 1'b0, 1'b0);
      test_end("check byte and reset");
      cfg.openLoop = 1'b1;
      repeat (8) @(negedge clk);
      chk_out();
      cfg.openLoop = 1'b0;
      cfg.overTemp = 1'b1;
      repeat (8) @(negedge clk);
      chk_out();
      send(cfg.addrStrap, 1'b1, 1'b0, 1'b1, 1'b0);
      test_end("faults");
      cfg.hwSel = 1'b1;
      for (int i = 0; i < 8; i++) begin
         cfg.senseSelPin = i[0];
         cfg.rangePin = rtab[i>>1];
         cfg.openLoop = i[1];
         cfg.overTemp = i[2];
         repeat (8) @(negedge clk);
         `CHK({rng, sense}, {cfg.rangePin, cfg.senseSelPin})
         `CHK(kind, kind_of(cfg.senseSelPin, cfg.rangePin))
         `CHK({olOe, tOe}, {cfg.openLoop, cfg.overTemp})
         `CHK({olOut, tOut, fOe}, 3'b000)
      end
      test_end("pin mode");
      final_report();
   end
endmodule // tb_top
`default_nettype wire
